//--- dac_cmd_regs.svh
`ifndef DAC_CMD_REGS_SVH
`define DAC_CMD_REGS_SVH

// command codes, top nibble of a frame or of the i2c command byte
`define CMD_NOP          4'h0
`define CMD_WR_INPUT     4'h1
`define CMD_UPDATE       4'h2
`define CMD_WR_BOTH      4'h3
`define CMD_WR_CTRL      4'h4

`define CODE_BITS        10
`define SPI_WORD_W       16
`define CHAIN_W          24
`define CHAIN_WORD_LSB   8
`define SPI_WORD_EDGES   6'h10
`define CHAIN_EDGES      6'h18
`define EDGE_MAX         6'h3f

// control field positions inside the 10-bit code field
`define CTRL_RESET_BIT   9
`define CTRL_PD_HI_BIT   8
`define CTRL_PD_LO_BIT   7
`define CTRL_REF_BIT     6
`define CTRL_GAIN_BIT    5
`define CTRL_CHAIN_BIT   4

`define I2C_ADDR_HI5     5'h13
`define I2C_ADDR_LSB     1'h0
`define I2C_DIR_WRITE    1'h0
`define I2C_BYTE_BITS    4'h8
`define I2C_LAST_BYTE    2'h2
`define I2C_GEN_CALL     7'h00

`endif

//--- dac_cmd_pkg.sv
`include "dac_cmd_regs.svh"
package dac_cmd_pkg;

    typedef logic [`CODE_BITS-1:0] code_t;

    typedef struct packed {
        logic pd_hi;
        logic pd_lo;
        logic ref_dis;
        logic gain;
        logic chain;
    } ctrl_t;

    typedef struct packed {
        logic sync_n;
        logic sclk;
        logic sdi;
    } spi_pins_t;

    typedef enum logic [2:0] {
        I2C_IDLE     = 3'b000,
        I2C_ADDR     = 3'b001,
        I2C_ADDR_ACK = 3'b010,
        I2C_DATA     = 3'b011,
        I2C_DATA_ACK = 3'b100,
        I2C_IGNORE   = 3'b101
    } i2c_state_t;

    typedef struct packed {
        logic                   sync_n_q;
        logic                   sclk_q;
        logic [5:0]             edges;
        logic [`SPI_WORD_W-1:0] first;
        logic [`CHAIN_W-1:0]    last;
        logic                   valid;
        logic [`SPI_WORD_W-1:0] word;
    } spi_rx_state_t;

    typedef struct packed {
        ctrl_t      ctrl;
        code_t      input_code;
        code_t      output_code;
        logic       strobe;
        i2c_state_t st;
        logic       scl_q;
        logic       sda_q;
        logic       addr_lat;
        logic [3:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] shreg;
        logic [7:0] cmd_byte;
        logic [7:0] hi_byte;
        logic       sda_oe;
    } top_state_t;

endpackage

//--- pin_sync.sv
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // meta is read by the second stage only
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = i_async;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sync = s_r.sync;
endmodule

//--- spi_frame_rx.sv
`include "dac_cmd_regs.svh"
module spi_frame_rx (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  dac_cmd_pkg::spi_pins_t      i_pins,
    input  wire logic                   i_chain_en,
    output logic                        o_valid,
    output logic [`SPI_WORD_W-1:0]      o_word
);
    import dac_cmd_pkg::*;

    spi_rx_state_t s_r;
    spi_rx_state_t s_nxt;
    logic          sync_rise;
    logic          sclk_fall;
    logic [`SPI_WORD_W-1:0] chain_word;

    assign sync_rise  = i_pins.sync_n && !s_r.sync_n_q;
    assign sclk_fall  = s_r.sclk_q && !i_pins.sclk;
    assign chain_word = s_r.last[`CHAIN_W-1:`CHAIN_WORD_LSB];

    always_comb begin
        s_nxt          = s_r;
        s_nxt.valid    = 1'h0;
        s_nxt.sync_n_q = i_pins.sync_n;
        s_nxt.sclk_q   = i_pins.sclk;
        if (i_pins.sync_n) begin
            if (sync_rise) begin
                if (i_chain_en) begin
                    if (s_r.edges > `CHAIN_EDGES) begin
                        s_nxt.valid = 1'h1;
                        s_nxt.word  = chain_word;
                    end
                end else if (s_r.edges >= `SPI_WORD_EDGES) begin
                    s_nxt.valid = 1'h1;
                    s_nxt.word  = s_r.first;
                end
            end
            s_nxt.edges = '0;
        end else if (sclk_fall) begin
            s_nxt.last = {s_r.last[`CHAIN_W-2:0], i_pins.sdi};
            if (s_r.edges < `SPI_WORD_EDGES) begin
                s_nxt.first = {s_r.first[`SPI_WORD_W-2:0], i_pins.sdi};
            end
            if (s_r.edges != `EDGE_MAX) begin
                s_nxt.edges = s_r.edges + 6'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_valid = s_r.valid;
    assign o_word  = s_r.word;

    AST_SHORT_FRAME_DROPPED:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            (sync_rise && s_r.edges < `SPI_WORD_EDGES) |=> !o_valid)
        else $error("short frame was accepted");

    AST_WORD_FRAME_TAKEN:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            (sync_rise && !i_chain_en && s_r.edges >= `SPI_WORD_EDGES)
            |=> (o_valid && o_word == $past(s_r.first)))
        else $error("valid frame lost or wrong word");

    AST_CHAIN_FRAME:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            (sync_rise && i_chain_en)
            |=> (o_valid == ($past(s_r.edges) > `CHAIN_EDGES))
                && (!o_valid || o_word == $past(chain_word)))
        else $error("chain frame decode wrong");

    AST_CAPTURE_ON_FALL:
        assert property (@(posedge i_clk) disable iff (!i_resetn)
            (!i_pins.sync_n && sclk_fall) |=> s_r.last[0] == $past(i_pins.sdi))
        else $error("bit not captured on falling edge");
endmodule

//--- dac_command_port.sv
`include "dac_cmd_regs.svh"
// Overview of operation
// - frame select low opens a write; data bit captured on each falling clock edge.
// - rise after 16 or more falling edges is valid; first 16 bits decoded.
// - rise before 16 falling edges discards the frame; nothing executes.
// - serial port has no data output; only the last device of a chain.
// - chain framing off after reset; enabled only by a control write.
// - chain on: frames over 24 bits valid, last 24 decoded, 10 LSBs ignored.
// - top nibble is the command; code in DB11..DB2; DB1..DB0 ignored.
// - serial control write: reset, pd high, pd low, ref off, gain, chain.
// - two-wire port works at 100 kHz and 400 kHz bus clocks.
// - no 10-bit or general call addressing; only own 7-bit address answered.
// - start is data falling while clock high; next byte is address plus direction.
// - matching address is acknowledged by holding data low on ninth clock.
// - nine clocks per byte; data changes only while clock is low.
// - address is 10011, then address select pin, then zero.
// - address select pin sampled per transaction, at start.
// - write is address, command, data high, data low, stop; all bytes acknowledged.
// - command in bits 7..4; code 9..2 in high byte, 1..0 in low 7..6.
// - two-wire control write uses code bits 9..5; no chain bit there.
// - update copies input register to output register; data ignored.
// - writing output register also writes the input register.
// - power-down pair selects load; output register stays writable.
// - soft reset restores all registers to defaults and clears itself.
module dac_command_port (
    input  wire logic            I_CLK,
    input  wire logic            I_RESETN,
    input  wire logic            I_SYNC_N,
    input  wire logic            I_SCLK,
    input  wire logic            I_SDI,
    input  wire logic            I_SCL,
    input  wire logic            I_SDA,
    input  wire logic            I_ADDR_SELECT_PIN,
    output logic                 O_SDA_OUT,
    output logic                 O_SDA_OE,
    output dac_cmd_pkg::code_t   O_INPUT_CODE,
    output dac_cmd_pkg::code_t   O_OUTPUT_CODE,
    output dac_cmd_pkg::ctrl_t   O_CTRL,
    output logic                 O_CMD_STROBE
);
    import dac_cmd_pkg::*;

    top_state_t s_r;
    top_state_t s_nxt;

    logic [5:0]             pins;
    spi_pins_t              spi_pins;
    logic                   scl;
    logic                   sda;
    logic                   addr_pin;
    logic                   spi_valid;
    logic [`SPI_WORD_W-1:0] spi_word;
    logic [3:0]             spi_cmd;
    code_t                  spi_code;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start;
    logic                   stop;
    logic [6:0]             own_addr;
    logic                   addr_hit;
    logic                   byte_done;
    logic                   i2c_go;
    logic [3:0]             i2c_cmd;
    code_t                  i2c_code;

    // every pin crosses in through two flops before any decode
    pin_sync #(
        .W(6)
    ) u_pin_sync (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_async  ({I_SYNC_N, I_SCLK, I_SDI, I_SCL, I_SDA, I_ADDR_SELECT_PIN}),
        .o_sync   (pins)
    );

    assign spi_pins = pins[5:3];
    assign scl      = pins[2];
    assign sda      = pins[1];
    assign addr_pin = pins[0];

    // receive-only port: nothing is shifted back out
    spi_frame_rx u_spi_rx (
        .i_clk      (I_CLK),
        .i_resetn   (I_RESETN),
        .i_pins     (spi_pins),
        .i_chain_en (s_r.ctrl.chain),
        .o_valid    (spi_valid),
        .o_word     (spi_word)
    );

    // decode only once the frame has closed
    assign spi_cmd  = spi_word[`SPI_WORD_W-1:`SPI_WORD_W-4];
    assign spi_code = spi_word[`SPI_WORD_W-5:2];

    // a fast-mode half period is ~156 clocks, far above the 3-cycle sync lag
    assign scl_rise = scl && !s_r.scl_q;
    assign scl_fall = !scl && s_r.scl_q;
    assign start    = scl && s_r.scl_q && s_r.sda_q && !sda;
    assign stop     = scl && s_r.scl_q && !s_r.sda_q && sda;

    assign own_addr  = {`I2C_ADDR_HI5, s_r.addr_lat, `I2C_ADDR_LSB};
    // general call and 10-bit prefixes never equal own_addr
    assign addr_hit  = (s_r.shreg[7:1] == own_addr) && (s_r.shreg[0] == `I2C_DIR_WRITE);
    assign byte_done = (s_r.bit_cnt == `I2C_BYTE_BITS);

    assign i2c_go   = (s_r.st == I2C_DATA) && scl_fall && byte_done
                      && (s_r.byte_cnt == `I2C_LAST_BYTE) && !start && !stop;
    assign i2c_cmd  = s_r.cmd_byte[7:4];
    assign i2c_code = {s_r.hi_byte, s_r.shreg[7:6]};

    function automatic top_state_t exec(
        input top_state_t cur,
        input logic [3:0] cmd,
        input code_t      code,
        input logic       from_spi
    );
        top_state_t r;
        r        = cur;
        r.strobe = 1'h1;
        case (cmd)
            `CMD_WR_INPUT: begin
                r.input_code = code;
            end
            `CMD_UPDATE: begin
                r.output_code = cur.input_code;
            end
            `CMD_WR_BOTH: begin
                r.input_code  = code;
                r.output_code = code;
            end
            `CMD_WR_CTRL: begin
                if (code[`CTRL_RESET_BIT]) begin
                    r.ctrl        = '0;
                    r.input_code  = '0;
                    r.output_code = '0;
                end else begin
                    // code registers untouched by power-down
                    r.ctrl.pd_hi   = code[`CTRL_PD_HI_BIT];
                    r.ctrl.pd_lo   = code[`CTRL_PD_LO_BIT];
                    r.ctrl.ref_dis = code[`CTRL_REF_BIT];
                    r.ctrl.gain    = code[`CTRL_GAIN_BIT];
                    if (from_spi) begin
                        r.ctrl.chain = code[`CTRL_CHAIN_BIT];
                    end
                end
            end
            default: begin
            end
        endcase
        return r;
    endfunction

    always_comb begin
        s_nxt        = s_r;
        s_nxt.strobe = 1'h0;
        s_nxt.scl_q  = scl;
        s_nxt.sda_q  = sda;
        if (start) begin
            s_nxt.st       = I2C_ADDR;
            s_nxt.bit_cnt  = '0;
            s_nxt.byte_cnt = '0;
            s_nxt.sda_oe   = 1'h0;
            s_nxt.addr_lat = addr_pin;
        end else if (stop) begin
            s_nxt.st     = I2C_IDLE;
            s_nxt.sda_oe = 1'h0;
        end else begin
            // sample on the rising clock, act on the falling clock
            if (scl_rise && !byte_done && (s_r.st == I2C_ADDR || s_r.st == I2C_DATA)) begin
                s_nxt.shreg   = {s_r.shreg[6:0], sda};
                s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            end
            if (scl_fall) begin
                case (s_r.st)
                    I2C_ADDR: begin
                        if (byte_done) begin
                            if (addr_hit) begin
                                s_nxt.st     = I2C_ADDR_ACK;
                                s_nxt.sda_oe = 1'h1;
                            end else begin
                                s_nxt.st = I2C_IGNORE;
                            end
                        end
                    end
                    I2C_ADDR_ACK: begin
                        s_nxt.st      = I2C_DATA;
                        s_nxt.sda_oe  = 1'h0;
                        s_nxt.bit_cnt = '0;
                    end
                    I2C_DATA: begin
                        if (byte_done) begin
                            s_nxt.st     = I2C_DATA_ACK;
                            s_nxt.sda_oe = 1'h1;
                            if (s_r.byte_cnt == 2'h0) begin
                                s_nxt.cmd_byte = s_r.shreg;
                            end
                            if (s_r.byte_cnt == 2'h1) begin
                                s_nxt.hi_byte = s_r.shreg;
                            end
                        end
                    end
                    I2C_DATA_ACK: begin
                        s_nxt.sda_oe  = 1'h0;
                        s_nxt.bit_cnt = '0;
                        // bytes past the data low byte are not acknowledged
                        if (s_r.byte_cnt == `I2C_LAST_BYTE) begin
                            s_nxt.st = I2C_IGNORE;
                        end else begin
                            s_nxt.st       = I2C_DATA;
                            s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // both ports may finish in one cycle; serial first, then two-wire
        if (spi_valid) begin
            s_nxt = exec(s_nxt, spi_cmd, spi_code, 1'h1);
        end
        if (i2c_go) begin
            s_nxt = exec(s_nxt, i2c_cmd, i2c_code, 1'h0);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // open drain: the pin is only ever pulled low
    assign O_SDA_OUT     = 1'h0;
    assign O_SDA_OE      = s_r.sda_oe;
    assign O_INPUT_CODE  = s_r.input_code;
    assign O_OUTPUT_CODE = s_r.output_code;
    assign O_CTRL        = s_r.ctrl;
    assign O_CMD_STROBE  = s_r.strobe;

    AST_RESET_DEFAULTS:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            $rose(I_RESETN) |-> (O_CTRL == '0 && O_INPUT_CODE == '0 && O_OUTPUT_CODE == '0))
        else $error("registers not at defaults after reset");

    AST_UPDATE_COPIES:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            (spi_valid && spi_cmd == `CMD_UPDATE && !i2c_go)
            |=> (O_OUTPUT_CODE == $past(O_INPUT_CODE) && $stable(O_INPUT_CODE)))
        else $error("update did not copy input register");

    AST_WRITE_BOTH:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            (spi_valid && spi_cmd == `CMD_WR_BOTH && !i2c_go)
            |=> (O_INPUT_CODE == $past(spi_code) && O_OUTPUT_CODE == O_INPUT_CODE))
        else $error("write both left registers unequal");

    AST_SOFT_RESET:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            (spi_valid && spi_cmd == `CMD_WR_CTRL && spi_code[`CTRL_RESET_BIT] && !i2c_go)
            |=> (O_CTRL == '0 && O_INPUT_CODE == '0 && O_OUTPUT_CODE == '0))
        else $error("soft reset incomplete");

    AST_ADDR_ACK:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            (s_r.st == I2C_ADDR && scl_fall && byte_done && addr_hit && !start && !stop)
            |=> O_SDA_OE ##1 (O_SDA_OE || !scl))
        else $error("matching address not acknowledged");

    AST_NO_GEN_CALL:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            (s_r.st == I2C_ADDR && byte_done && s_r.shreg[7:1] == `I2C_GEN_CALL)
            |=> !O_SDA_OE)
        else $error("general call acknowledged");

    AST_ACK_RELEASE:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            ((s_r.st == I2C_ADDR_ACK || s_r.st == I2C_DATA_ACK) && scl_fall)
            |=> !O_SDA_OE)
        else $error("acknowledge not released after ninth clock");

    AST_I2C_NO_CHAIN:
        assert property (@(posedge I_CLK) disable iff (!I_RESETN)
            (i2c_go && !spi_valid && !(i2c_cmd == `CMD_WR_CTRL && i2c_code[`CTRL_RESET_BIT]))
            |=> $stable(O_CTRL.chain))
        else $error("two-wire write touched chain enable");
endmodule

//--- serial_host.sv
module serial_host (
    input  wire logic i_clk,
    input  wire logic i_oe,
    input  wire logic i_sda_out,
    output logic      o_sync_n,
    output logic      o_sclk,
    output logic      o_sdi,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    logic sda_rel;
    // quarter of a two-wire bit in clocks; the bench raises it for bus-speed runs
    int   qtr = 8;

    // pulled-up wire: low while either party pulls it
    assign o_sda = sda_rel & ~(i_oe & ~i_sda_out);

    initial begin
        o_sync_n = 1'b1;
        o_sclk   = 1'b1;
        o_sdi    = 1'b0;
        o_scl    = 1'b1;
        sda_rel  = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // serial clock stands high outside frames; sole device at the end of the line
    task automatic spi_frame(input logic [31:0] v, input int n);
        tick(1);
        o_sync_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi <= v[i];
            tick(4);
            o_sclk <= 1'b0;
            tick(4);
            o_sclk <= 1'b1;
        end
        tick(4);
        o_sync_n <= 1'b1;
        // a released data line must not keep the last bit
        o_sdi <= ~v[0];
        tick(12);
    endtask

    task automatic i2c_bit(input logic b, output logic r);
        o_scl <= 1'b0;
        tick(qtr);
        sda_rel <= b;
        tick(qtr);
        o_scl <= 1'b1;
        tick(qtr);
        r = o_sda;
        tick(qtr);
    endtask

    // four bytes, each followed by a released ack slot, then stop
    task automatic i2c_write(input logic [31:0] v, output logic [3:0] acks);
        logic r;
        tick(1);
        sda_rel <= 1'b0;
        tick(qtr);
        for (int k = 3; k >= 0; k--) begin
            for (int i = 7; i >= 0; i--) begin
                i2c_bit(v[8*k+i], r);
            end
            i2c_bit(1'b1, r);
            acks[k] = ~r;
        end
        o_scl <= 1'b0;
        tick(qtr);
        sda_rel <= 1'b0;
        tick(qtr);
        o_scl <= 1'b1;
        tick(qtr);
        sda_rel <= 1'b1;
        tick(16);
    endtask
endmodule

//--- tb_dac_command_port.sv
`include "dac_cmd_regs.svh"
module tb_dac_command_port;
    timeunit 1ns;
    timeprecision 100ps;
    import dac_cmd_pkg::*;

    typedef struct packed {
        code_t in_code;
        code_t out_code;
        ctrl_t ctrl;
    } exp_t;

    logic       clk;
    logic       resetn;
    logic       sync_n;
    logic       sclk;
    logic       sdi;
    logic       scl;
    logic       sda;
    logic       addr_sel;
    logic       sda_out;
    logic       sda_oe;
    logic       strobe;
    code_t      in_code;
    code_t      out_code;
    ctrl_t      ctrl;
    exp_t       model;
    exp_t       q[$];
    logic [3:0] acks;
    code_t      c;
    int         n_errors = 0;
    int         checked  = 0;
    int         cycles   = 0;
    int         seed     = 9804;

    dac_command_port DUT (.I_CLK(clk), .I_RESETN(resetn), .I_SYNC_N(sync_n), .I_SCLK(sclk), .I_SDI(sdi),
        .I_SCL(scl), .I_SDA(sda), .I_ADDR_SELECT_PIN(addr_sel), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
        .O_INPUT_CODE(in_code), .O_OUTPUT_CODE(out_code), .O_CTRL(ctrl), .O_CMD_STROBE(strobe));

    serial_host host (.i_clk(clk), .i_oe(sda_oe), .i_sda_out(sda_out), .o_sync_n(sync_n), .o_sclk(sclk),
        .o_sdi(sdi), .o_scl(scl), .o_sda(sda));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic summarize;
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the run should need about 24000 cycles, one two-wire write at bus speed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            $display("mismatch at %0t: run did not finish", $time);
            summarize();
        end
    end

    task automatic check_regs(input exp_t e);
        checked++;
        if ({in_code, out_code, ctrl} !== e) begin
            n_errors++;
            $display("mismatch at %0t: registers %h expected %h", $time, {in_code, out_code, ctrl}, e);
        end
    endtask

    task automatic check_bits(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(negedge clk) begin
        if (resetn === 1'b1 && strobe === 1'b1) begin
            if (q.size() == 0) begin
                n_errors++;
                $display("mismatch at %0t: command executed unasked", $time);
            end else begin
                check_regs(q.pop_front());
            end
        end
    end

    task automatic expect_cmd(input logic [3:0] cmd, input code_t code, input logic spi);
        case (cmd)
            `CMD_WR_INPUT: model.in_code = code;
            `CMD_UPDATE: model.out_code = model.in_code;
            `CMD_WR_BOTH: begin
                model.in_code = code;
                model.out_code = code;
            end
            `CMD_WR_CTRL: begin
                if (code[9]) begin
                    model = '0;
                end else begin
                    model.ctrl = {code[8:5], spi ? code[4] : model.ctrl.chain};
                end
            end
            default: ;
        endcase
        q.push_back(model);
    endtask

    task automatic spi(input logic [3:0] cmd, input code_t code);
        expect_cmd(cmd, code, 1'b1);
        host.spi_frame({16'h0, cmd, code, {2{cmd != 4'h4}}}, 16);
    endtask

    task automatic i2c(input logic [6:0] addr, input logic rw, input logic [3:0] cmd, input code_t code,
                       input logic ok);
        logic [3:0] f = (cmd == 4'h4) ? 4'h0 : 4'hf;
        if (ok) begin
            expect_cmd(cmd, code, 1'b0);
        end
        host.i2c_write({addr, rw, cmd, f, code, f[1:0], f}, acks);
        check_bits({28'h0, acks}, ok ? 32'hf : 32'h0);
    endtask

    initial begin
        resetn = 1'b0;
        addr_sel = 1'b0;
        model = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        check_regs('0);
        spi(`CMD_WR_INPUT, 10'h3ff);
        spi(`CMD_UPDATE, 10'h155);
        spi(`CMD_NOP, 10'h2aa);
        c = 10'($random(seed));
        spi(`CMD_WR_BOTH, c);
        c = 10'($random(seed));
        host.spi_frame({17'h0, `CMD_WR_BOTH, c, 1'b0}, 15);
        expect_cmd(`CMD_WR_INPUT, c, 1'b1);
        host.spi_frame({12'h0, `CMD_WR_INPUT, c, 2'b0, 4'ha}, 20);
        for (int p = 0; p < 4; p++) begin
            spi(`CMD_WR_CTRL, {1'b0, p[1:0], 1'b1, 1'b1, 5'h0});
        end
        spi(`CMD_WR_CTRL, 10'h030);
        host.spi_frame({16'h0, `CMD_WR_INPUT, 10'h3ff, 2'b0}, 16);
        host.spi_frame({8'h0, `CMD_WR_INPUT, 10'h3ff, 2'b0, 8'h0}, 24);
        c = 10'($random(seed));
        expect_cmd(`CMD_WR_INPUT, c, 1'b1);
        host.spi_frame({7'h0, 1'b1, `CMD_WR_INPUT, c, 2'b0, 8'h5a}, 25);
        c = 10'($random(seed));
        expect_cmd(`CMD_WR_BOTH, c, 1'b1);
        host.spi_frame({8'hc3, `CMD_WR_BOTH, c, 2'b11, 8'h3c}, 32);
        expect_cmd(`CMD_WR_CTRL, 10'h200, 1'b1);
        host.spi_frame({7'h0, 1'b0, `CMD_WR_CTRL, 10'h200, 2'b0, 8'h0}, 25);
        c = 10'($random(seed));
        spi(`CMD_WR_INPUT, c);
        c = 10'($random(seed));
        i2c(7'h4c, 1'b0, `CMD_WR_BOTH, c, 1'b1);
        addr_sel <= 1'b1;
        i2c(7'h4e, 1'b0, `CMD_WR_INPUT, ~c, 1'b1);
        i2c(7'h4c, 1'b0, `CMD_WR_INPUT, c, 1'b0);
        i2c(7'h00, 1'b0, `CMD_WR_INPUT, c, 1'b0);
        i2c(7'h78, 1'b0, `CMD_WR_INPUT, c, 1'b0);
        i2c(7'h4e, 1'b1, `CMD_WR_INPUT, c, 1'b0);
        i2c(7'h4e, 1'b0, `CMD_UPDATE, c, 1'b1);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        model = '0;
        repeat (8) @(posedge clk);
        check_regs('0);
        spi(`CMD_WR_CTRL, 10'h010);
        // a 316-clock bit period is just under 400 kHz
        host.qtr = 79;
        i2c(7'h4e, 1'b0, `CMD_WR_CTRL, 10'h1e0, 1'b1);
        host.qtr = 8;
        i2c(7'h4e, 1'b0, `CMD_WR_CTRL, 10'h200, 1'b1);
        repeat (20) @(posedge clk);
        check_bits(q.size(), 0);
        summarize();
    end
endmodule
